//--- sp_relative_compressed_ldst_expander_tb_top.sv
// self-checking bench for the stack load/store expander
// assumes the fetch model, the props checker and the expander are compiled first
`timescale 1ns/1ns
`default_nettype none
module sp_relative_compressed_ldst_expander_tb_top;
    logic               sys_clk_i, rst_n_i, send, fs, fd, ev, sl, il, pv, exp_v, exp_ok; // clock, drives, outputs
    logic [15:0]        word, pw;    // requested and presented parcel
    logic [31:0]        ex, r;       // expansion and random draw
    logic [33:0]        exp_r;       // expected match, illegal, expansion
    spx_pkg::spx_base_t base;        // configured base
    int                 n_errors, check_count, cycles;
    spx_fetch_model fetch (.sys_clk_i, .rst_n_i, .send_i(send), .word_i(word), .parcel_valid_o(pv), .parcel_o(pw));
    spx_expander dut (.sys_clk_i, .rst_n_i, .parcel_valid_i(pv), .parcel_i(pw), .base_i(base),
        .has_float_single_i(fs), .has_float_double_i(fd), .expanded_valid_o(ev), .stack_ldst_o(sl),
        .illegal_o(il), .expanded_o(ex));
    // load and store layouts, based on the stack pointer
    function automatic logic [31:0] ld_enc(logic [11:0] o, logic [2:0] f3, logic [4:0] rd, logic [6:0] op);
        return {o, 5'h02, f3, rd, op};
    endfunction
    function automatic logic [31:0] st_enc(logic [11:0] o, logic [2:0] f3, logic [4:0] rs, logic [6:0] op);
        return {o[11:5], rs, 5'h02, f3, o[4:0], op};
    endfunction
    // expected {match, illegal, expansion} for one parcel and configuration
    function automatic logic [33:0] ref_expand(logic [15:0] p, logic [1:0] b, logic s, logic d);
        logic [11:0] lw, ld, lq, sw, sd, sq;
        logic        z;
        logic [33:0] v;
        z  = (p[11:7] == 5'h00);
        lw = {4'h0, p[3:2], p[12], p[6:4], 2'h0};
        ld = {3'h0, p[4:2], p[12], p[6:5], 3'h0};
        lq = {2'h0, p[5:2], p[12], p[6], 4'h0};
        sw = {4'h0, p[8:7], p[12:9], 2'h0};
        sd = {3'h0, p[9:7], p[12:10], 3'h0};
        sq = {2'h0, p[10:7], p[12:11], 4'h0};
        v  = 34'h0;
        if (p[1:0] == 2'h2) begin
            case (p[15:13])
                3'h2: v = {1'b1, z, ld_enc(lw, 3'h2, p[11:7], 7'h03)};
                3'h6: v = {1'b1, 1'b0, st_enc(sw, 3'h2, p[6:2], 7'h23)};
                3'h3: v = b == 2'h0 ? {1'b1, !s, ld_enc(lw, 3'h2, p[11:7], 7'h07)}
                                    : {1'b1, z, ld_enc(ld, 3'h3, p[11:7], 7'h03)};
                3'h7: v = b == 2'h0 ? {1'b1, !s, st_enc(sw, 3'h2, p[6:2], 7'h27)}
                                    : {2'b10, st_enc(sd, 3'h3, p[6:2], 7'h23)};
                3'h1: v = b == 2'h2 ? {1'b1, z, ld_enc(lq, 3'h2, p[11:7], 7'h0f)}
                                    : {1'b1, !d, ld_enc(ld, 3'h3, p[11:7], 7'h07)};
                3'h5: v = b == 2'h2 ? {2'b10, st_enc(sq, 3'h4, p[6:2], 7'h23)}
                                    : {1'b1, !d, st_enc(sd, 3'h3, p[6:2], 7'h27)};
                default: v = 34'h0;
            endcase
        end
        // an unsupported base code refuses every stack form
        if (b == 2'h3 && v[33]) v[32] = 1'b1;
        return v;
    endfunction
    task automatic check_bit(logic got, logic want);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic check_word(logic [31:0] got, logic [31:0] want);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic send_one(logic v, logic [15:0] p);
        @(posedge sys_clk_i);
        send <= v;
        word <= p;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // expectation from inputs seen at each edge, with a cycle ceiling
    always @(posedge sys_clk_i) begin
        exp_ok <= rst_n_i;
        exp_v  <= pv;
        exp_r  <= pv ? ref_expand(pw, base, fs, fd) : 34'h0;
        cycles <= cycles + 1;
        if (cycles > 3000) begin
            n_errors++;
            results();
        end
    end
    // results compared mid-cycle, once they have settled
    always @(negedge sys_clk_i) begin
        if (exp_ok && rst_n_i) begin
            check_bit(ev, exp_v);
            check_bit(sl, exp_r[33]);
            check_bit(il, exp_r[32]);
            check_word(ex, exp_r[31:0]);
        end
    end
    initial begin
        {rst_n_i, send, fs, fd, exp_ok, exp_v, word, exp_r} = '0;
        base = spx_pkg::SPX_BASE_32;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        void'($urandom(32'habe2));
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        // corners: back-to-back legal, zero-register, all-ones, other quadrant
        send_one(1'b1, 16'h4082);
        send_one(1'b1, 16'h4002);
        send_one(1'b1, 16'hfffe);
        send_one(1'b1, 16'h2002);
        send_one(1'b1, 16'h4081);
        // every base code, the unsupported one too, every extension mix and function code
        for (int c = 0; c < 16; c++) begin
            @(posedge sys_clk_i);
            base <= spx_pkg::spx_base_t'(c % 4);
            {fd, fs} <= 2'(c / 4);
            for (int i = 0; i < 48; i++) begin
                r = $urandom;
                send_one(r[16] | r[17], {3'(i), r[12], r[11:7] & {5{r[20]}}, r[6:2],
                                         r[21] ? 2'h2 : r[1:0]});
            end
        end
        send_one(1'b0, 16'h0000);
        repeat (3) @(posedge sys_clk_i);
        results();
    end
endmodule
bind spx_expander spx_expander_props u_props (.sys_clk_i, .rst_n_i, .parcel_valid_i, .parcel_i, .base_i,
    .has_float_single_i, .has_float_double_i, .expanded_valid_o, .stack_ldst_o, .illegal_o, .expanded_o);
`default_nettype wire

//--- spx_expander.sv
// expander for stack-pointer-relative compressed loads and stores
// assumes a 16-bit parcel from fetch in the core clock domain, config
// straps that are static while instructions flow, and a decoder downstream
//
// Overview of operation
// RQ1 - word stack load becomes lw, offset times 4
// RQ2 - word stack load to zero register is reserved
// RQ3 - 64/128 bases: double load becomes ld, times 8
// RQ4 - double stack load to zero is reserved
// RQ5 - 128 base: quad load becomes lq, times 16
// RQ6 - quad stack load to zero is reserved
// RQ7 - 32 base with single float: flw, times 4
// RQ8 - 32/64 base with double float: fld, times 8
// RQ9 - word stack store becomes sw, times 4
// RQ10 - 64/128 bases: double store becomes sd
// RQ11 - 128 base: quad store becomes sq
// RQ12 - 32 base with single float: fsw store
// RQ13 - 32/64 base with double float: fsd store
// RQ14 - load fields: code, offset bit, rd, offset
// RQ15 - store fields: code, six-bit offset, rs2
// RQ16 - offsets reassembled per size, zero-extended
// RQ17 - only low bits 10; unsupported forms illegal
`timescale 1ns/1ns
`default_nettype none

module spx_expander (
    input  wire logic              sys_clk_i,      // core clock, 125 MHz
    input  wire logic              rst_n_i,        // async reset, active low
    input  wire logic              parcel_valid_i, // parcel present this cycle
    input  wire logic [15:0]       parcel_i,       // compressed instruction parcel
    input  wire spx_pkg::spx_base_t base_i,        // configured integer base width
    input  wire logic              has_float_single_i, // single float extension present
    input  wire logic              has_float_double_i, // double float extension present
    output logic                   expanded_valid_o,   // result below is valid
    output logic                   stack_ldst_o,       // parcel was a stack load/store
    output logic                   illegal_o,          // reserved or unsupported form
    output logic [31:0]            expanded_o          // equivalent 32-bit instruction
);

    // decoded fields of the parcel
    logic [2:0]  func_code;          // function code field
    logic [4:0]  rd_field;           // full destination register
    logic [4:0]  rs2_field;          // full store source register
    logic        in_quadrant;        // low two bits select the stack quadrant

    // offsets reassembled per access size, in bytes (already scaled)
    logic [11:0] off_load_word;
    logic [11:0] off_load_double;
    logic [11:0] off_load_quad;
    logic [11:0] off_store_word;
    logic [11:0] off_store_double;
    logic [11:0] off_store_quad;

    // registered result and its next value
    logic        out_valid;
    logic        out_match;
    logic        out_illegal;
    logic [31:0] out_instr;
    logic        next_out_valid;
    logic        next_out_match;
    logic        next_out_illegal;
    logic [31:0] next_out_instr;

    // field extraction is wiring only
    // rd and rs2 are full five-bit fields, so every register is reachable
    assign func_code   = parcel_i[spx_pkg::POS_FC_LSB +: 3];            // [RQ14] [RQ15]
    assign rd_field    = parcel_i[spx_pkg::POS_RD_LSB +: 5];           // [RQ14]
    assign rs2_field   = parcel_i[spx_pkg::POS_RS2_LSB +: 5];          // [RQ15]
    assign in_quadrant = (parcel_i[1:0] == spx_pkg::QUADRANT_STACK);   // [RQ17]

    // load offsets: bit 5 from bit 12, the rest from bits 6..2, high bits lowest
    // word: offset 7..6 sit in bits 3..2, offset 4..2 in bits 6..4
    // double: offset 8..6 sit in bits 4..2, offset 4..3 in bits 6..5
    // quad: offset 9..6 sit in bits 5..2, offset 4 in bit 6
    assign off_load_word   = {4'h0, parcel_i[3:2], parcel_i[12], parcel_i[6:4], 2'h0};   // [RQ16] [RQ1]
    assign off_load_double = {3'h0, parcel_i[4:2], parcel_i[12], parcel_i[6:5], 3'h0};   // [RQ16] [RQ3]
    assign off_load_quad   = {2'h0, parcel_i[5:2], parcel_i[12], parcel_i[6], 4'h0};     // [RQ16] [RQ5]

    // store offsets: six-bit field in bits 12..7, low scaled bits first
    // word: offset 5..2 in bits 12..9, offset 7..6 in bits 8..7
    // double: offset 5..3 in bits 12..10, offset 8..6 in bits 9..7
    // quad: offset 5..4 in bits 12..11, offset 9..6 in bits 10..7
    // the scaled low bits are zero, so an access is never misaligned
    assign off_store_word   = {4'h0, parcel_i[8:7], parcel_i[12:9], 2'h0};               // [RQ16] [RQ9]
    assign off_store_double = {3'h0, parcel_i[9:7], parcel_i[12:10], 3'h0};              // [RQ16] [RQ10]
    assign off_store_quad   = {2'h0, parcel_i[10:7], parcel_i[12:11], 4'h0};             // [RQ16] [RQ11]

    // build a 32-bit immediate-form load based on the stack pointer
    // the twelve-bit immediate is zero-extended, so the reach is upward only
    function automatic logic [31:0] make_load(input logic [11:0] off, input logic [2:0] f3,
                                              input logic [4:0] rd, input logic [6:0] opc);
        return {off, spx_pkg::REG_STACK_POINTER, f3, rd, opc};
    endfunction

    // build a 32-bit split-immediate store based on the stack pointer
    // immediate bits 11..5 sit above rs2 and bits 4..0 above the opcode
    function automatic logic [31:0] make_store(input logic [11:0] off, input logic [2:0] f3,
                                               input logic [4:0] rs2, input logic [6:0] opc);
        return {off[11:5], rs2, spx_pkg::REG_STACK_POINTER, f3, off[4:0], opc};
    endfunction

    // decode and expand; anything outside the stack forms passes with no match
    // the expansion is filled in even when the form is illegal, so the decoder
    // downstream can report the faulting word; the illegal flag alone decides
    // whether the result may issue
    // the base and extension straps are read directly: they must not change
    // while parcels flow, since nothing here resynchronises them
    always_comb begin
        next_out_valid   = parcel_valid_i;
        next_out_match   = 1'b0;
        next_out_illegal = 1'b0;
        next_out_instr   = spx_pkg::RST_EXPANDED;
        if (parcel_valid_i && in_quadrant) begin // [RQ17]
            case (func_code)
                // word stack load, any base
                spx_pkg::FC_LOAD_WORD: begin
                    // rd of zero is reserved; the encoding is still filled in
                    next_out_match   = 1'b1;
                    next_out_illegal = (rd_field == spx_pkg::REG_HARDWIRED_ZERO); // [RQ2]
                    next_out_instr   = make_load(off_load_word, spx_pkg::F3_WORD, rd_field,
                                                 spx_pkg::OPC_LOAD); // [RQ1]
                end
                // double integer load on wide bases, single float load on 32
                spx_pkg::FC_LOAD_DOUBLE: begin
                    next_out_match = 1'b1;
                    if (base_i == spx_pkg::SPX_BASE_32) begin
                        // float single needs the extension
                        next_out_illegal = !has_float_single_i; // [RQ17]
                        next_out_instr   = make_load(off_load_word, spx_pkg::F3_WORD, rd_field,
                                                     spx_pkg::OPC_LOAD_FP); // [RQ7]
                    end else begin
                        next_out_illegal = (rd_field == spx_pkg::REG_HARDWIRED_ZERO); // [RQ4]
                        next_out_instr   = make_load(off_load_double, spx_pkg::F3_DOUBLE, rd_field,
                                                     spx_pkg::OPC_LOAD); // [RQ3]
                    end
                end
                // quad load on 128 base, double float load otherwise
                spx_pkg::FC_LOAD_QUAD: begin
                    next_out_match = 1'b1;
                    if (base_i == spx_pkg::SPX_BASE_128) begin
                        next_out_illegal = (rd_field == spx_pkg::REG_HARDWIRED_ZERO); // [RQ6]
                        next_out_instr   = make_load(off_load_quad, spx_pkg::F3_LOAD_QUAD, rd_field,
                                                     spx_pkg::OPC_MISC_MEM); // [RQ5]
                    end else begin
                        // float double load needs the extension
                        next_out_illegal = !has_float_double_i; // [RQ17]
                        next_out_instr   = make_load(off_load_double, spx_pkg::F3_DOUBLE, rd_field,
                                                     spx_pkg::OPC_LOAD_FP); // [RQ8]
                    end
                end
                // word stack store, any base
                spx_pkg::FC_STORE_WORD: begin
                    next_out_match = 1'b1;
                    next_out_instr = make_store(off_store_word, spx_pkg::F3_WORD, rs2_field,
                                                spx_pkg::OPC_STORE); // [RQ9]
                end
                // double store on wide bases, single float store on 32
                spx_pkg::FC_STORE_DOUBLE: begin
                    next_out_match = 1'b1;
                    if (base_i == spx_pkg::SPX_BASE_32) begin
                        // float single store needs the extension
                        next_out_illegal = !has_float_single_i; // [RQ17]
                        next_out_instr   = make_store(off_store_word, spx_pkg::F3_WORD, rs2_field,
                                                      spx_pkg::OPC_STORE_FP); // [RQ12]
                    end else begin
                        next_out_instr   = make_store(off_store_double, spx_pkg::F3_DOUBLE, rs2_field,
                                                      spx_pkg::OPC_STORE); // [RQ10]
                    end
                end
                // quad store on 128 base, double float store otherwise
                spx_pkg::FC_STORE_QUAD: begin
                    next_out_match = 1'b1;
                    if (base_i == spx_pkg::SPX_BASE_128) begin
                        next_out_instr   = make_store(off_store_quad, spx_pkg::F3_STORE_QUAD, rs2_field,
                                                      spx_pkg::OPC_STORE); // [RQ11]
                    end else begin
                        // float double store needs the extension
                        next_out_illegal = !has_float_double_i; // [RQ17]
                        next_out_instr   = make_store(off_store_double, spx_pkg::F3_DOUBLE, rs2_field,
                                                      spx_pkg::OPC_STORE_FP); // [RQ13]
                    end
                end
                // other forms of this quadrant belong to other decoders
                default: begin
                    next_out_match = 1'b0;
                end
            endcase
            // an unknown base code never yields a usable expansion
            // the would-be encoding still stands, so the flag alone blocks it
            if (next_out_match && (base_i != spx_pkg::SPX_BASE_32) && (base_i != spx_pkg::SPX_BASE_64)
                && (base_i != spx_pkg::SPX_BASE_128)) begin
                next_out_illegal = 1'b1; // [RQ17]
            end
        end
    end

    // register the result; one cycle from parcel to answer
    // every output reloads on every edge, so a stale result never outlives
    // its parcel by more than the one cycle of latency
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid   <= spx_pkg::RST_FLAG;
            out_match   <= spx_pkg::RST_FLAG;
            out_illegal <= spx_pkg::RST_FLAG;
            out_instr   <= spx_pkg::RST_EXPANDED;
        end else begin
            out_valid   <= next_out_valid;
            out_match   <= next_out_match;
            out_illegal <= next_out_illegal;
            out_instr   <= next_out_instr;
        end
    end

    // outputs straight from the flip-flops
    // expanded_valid_o follows parcel_valid_i by exactly one edge
    assign expanded_valid_o = out_valid;
    assign stack_ldst_o     = out_match;
    assign illegal_o        = out_illegal;
    assign expanded_o       = out_instr;

endmodule

`default_nettype wire

//--- spx_expander_props.sv
// assertions on the ports of the stack load/store expander
// assumes it is bound into the expander and watches its ports only
`timescale 1ns/1ns
`default_nettype none
module spx_expander_props (
    input wire logic               sys_clk_i,          // core clock
    input wire logic               rst_n_i,            // async reset, active low
    input wire logic               parcel_valid_i,     // parcel present
    input wire logic [15:0]        parcel_i,           // compressed parcel
    input wire spx_pkg::spx_base_t base_i,             // configured base
    input wire logic               has_float_single_i, // single float present
    input wire logic               has_float_double_i, // double float present
    input wire logic               expanded_valid_o,   // result valid
    input wire logic               stack_ldst_o,       // stack form matched
    input wire logic               illegal_o,          // reserved or unsupported
    input wire logic [31:0]        expanded_o          // expansion
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // a parcel in the stack quadrant with the given function code
    sequence s_take(logic [2:0] fc);
        parcel_valid_i && parcel_i[1:0] == 2'h2 && parcel_i[15:13] == fc;
    endsequence
    a_result_follows: assert property (parcel_valid_i |=> expanded_valid_o) else $error("result missing");
    a_idle_clears: assert property (
        !parcel_valid_i |=> !expanded_valid_o && !stack_ldst_o && expanded_o == 32'h0)
        else $error("idle cycle left a result");
    a_quadrant_gate: assert property (
        parcel_valid_i && parcel_i[1:0] != 2'h2 |=> !stack_ldst_o && !illegal_o)
        else $error("match outside stack quadrant");
    a_illegal_matched: assert property (illegal_o |-> stack_ldst_o) else $error("illegal without match");
    a_zero_rd_reserved: assert property (
        (s_take(3'h2) ##0 parcel_i[11:7] == 5'h00) |=> illegal_o)
        else $error("word load to zero register accepted");
    a_word_load_enc: assert property (s_take(3'h2) |=>
        expanded_o == {4'h0, $past(parcel_i[3:2]), $past(parcel_i[12]), $past(parcel_i[6:4]), 2'h0, 5'h02, 3'h2,
        $past(parcel_i[11:7]), 7'h03}) else $error("bad word load");
    a_word_store_enc: assert property (s_take(3'h6) |=>
        expanded_o == {4'h0, $past(parcel_i[8:7]), $past(parcel_i[12]), $past(parcel_i[6:2]), 5'h02, 3'h2,
        $past(parcel_i[11:9]), 2'h0, 7'h23}) else $error("bad word store");
    a_store_legal: assert property (
        (s_take(3'h6) ##0 base_i != 2'h3) |=> stack_ldst_o && !illegal_o)
        else $error("word store refused");
    a_single_gate: assert property (
        (s_take(3'h3) ##0 (base_i == spx_pkg::SPX_BASE_32 && !has_float_single_i)) |=> illegal_o)
        else $error("float single load without extension");
    a_base_unknown: assert property (
        base_i == 2'h3 ##1 stack_ldst_o |-> illegal_o)
        else $error("stack form accepted on unknown base");
endmodule
`default_nettype wire

//--- spx_fetch_model.sv
// fetch-stage model handing one parcel per cycle to the expander
// assumes the bench asks for parcels on the core clock
`timescale 1ns/1ns
`default_nettype none
module spx_fetch_model (
    input  wire logic        sys_clk_i,      // core clock
    input  wire logic        rst_n_i,        // async reset, active low
    input  wire logic        send_i,         // bench asks for a parcel
    input  wire logic [15:0] word_i,         // parcel to send
    output logic             parcel_valid_o, // parcel present
    output logic [15:0]      parcel_o        // parcel, scrambled while idle
);
    // idle cycles carry a changing pattern so stale parcels are never trusted
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            parcel_valid_o <= 1'b0;
            parcel_o       <= 16'h0000;
        end else begin
            parcel_valid_o <= send_i;
            parcel_o       <= send_i ? word_i : ~parcel_o;
        end
    end
endmodule
`default_nettype wire

//--- spx_pkg.sv
// constants shared by the stack-pointer-relative compressed load/store expander
// assumes a single core clock domain; the expander, the props checker and the bench all use it
`default_nettype none

package spx_pkg;

    // base integer width selection driven by the core configuration
    typedef enum logic [1:0] {
        SPX_BASE_32  = 2'b00,
        SPX_BASE_64  = 2'b01,
        SPX_BASE_128 = 2'b10
    } spx_base_t;

    // compressed quadrant that holds the stack-relative forms
    localparam logic [1:0] QUADRANT_STACK   = 2'h2;

    // function code field values within that quadrant
    localparam logic [2:0] FC_LOAD_QUAD     = 3'h1; // also float double load
    localparam logic [2:0] FC_LOAD_WORD     = 3'h2;
    localparam logic [2:0] FC_LOAD_DOUBLE   = 3'h3; // also float single load
    localparam logic [2:0] FC_STORE_QUAD    = 3'h5; // also float double store
    localparam logic [2:0] FC_STORE_WORD    = 3'h6;
    localparam logic [2:0] FC_STORE_DOUBLE  = 3'h7; // also float single store

    // field positions in the 16-bit parcel
    localparam int         POS_FC_LSB       = 13;
    localparam int         POS_RD_LSB       = 7;
    localparam int         POS_RS2_LSB      = 2;

    // 32-bit major opcodes
    localparam logic [6:0] OPC_LOAD         = 7'h03;
    localparam logic [6:0] OPC_LOAD_FP      = 7'h07;
    localparam logic [6:0] OPC_MISC_MEM     = 7'h0f;
    localparam logic [6:0] OPC_STORE        = 7'h23;
    localparam logic [6:0] OPC_STORE_FP     = 7'h27;

    // 32-bit width function codes
    localparam logic [2:0] F3_WORD          = 3'h2;
    localparam logic [2:0] F3_DOUBLE        = 3'h3;
    localparam logic [2:0] F3_STORE_QUAD    = 3'h4;
    localparam logic [2:0] F3_LOAD_QUAD     = 3'h2;

    // register numbers
    localparam logic [4:0] REG_STACK_POINTER = 5'h02;
    localparam logic [4:0] REG_HARDWIRED_ZERO = 5'h00;

    // values after reset
    localparam logic [31:0] RST_EXPANDED    = 32'h0000_0000;
    localparam logic        RST_FLAG        = 1'b0;

endpackage

`default_nettype wire
